// *** mbrf_pkg.sv ***
// package of constants and types for the b-protocol report formatter
package mbrf_pkg;
   localparam int MBRF_FIFO_DEPTH = 16;
   localparam int MBRF_ENTRY_W = 12;
   localparam logic [3:0] MBRF_LEN_MIN = 4'h8;
   localparam logic [3:0] MBRF_LEN_MAX = 4'hb;
   localparam logic [11:0] MBRF_FC_EMPTY = 12'h000;
   localparam logic [11:0] MBRF_FC_BITTIME = 12'h019;
   localparam logic [11:0] MBRF_FC_TOO_MANY = 12'h01a;
   localparam logic [11:0] MBRF_FC_PARITY = 12'h01c;
   localparam int MBRF_MARKER_POS = 11;
   localparam int MBRF_LOST_POS = 12;
   localparam int MBRF_PAR_POS = 13;
   localparam logic [1:0] MBRF_ST_OFF = 2'h0;
   localparam logic [1:0] MBRF_ST_DIS = 2'h1;
   localparam logic [1:0] MBRF_ST_EN = 2'h2;
   localparam logic [1:0] MBRF_ST_CFG = 2'h3;
   localparam logic [15:0] MBRF_CH2_RESET = 16'he000;

   // one received satellite message from the line decoder
   typedef struct packed {
      logic [10:0] data;
      logic [3:0] nbits;
      logic bit_time_err;
      logic parity_err;
   } mbrf_msg_t;

   typedef enum logic [2:0] {
      MBRF_CS_IDLE = 3'b001,
      MBRF_CS_LOW = 3'b010,
      MBRF_CS_POP = 3'b100
   } mbrf_cs_state_t;
endpackage

// *** mbrf_fifo.sv ***
// report entry fifo with valid/ready on both sides
`timescale 1ns/1ps
module mbrf_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic do_wr;
   logic do_rd;

   assign in_ready_o = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign do_wr = in_valid_i && in_ready_o;
   assign do_rd = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr];

   always_ff @(posedge clk_i) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule

// *** mbrf_formatter.sv ***
// b-protocol report formatter for both satellite channels
`timescale 1ns/1ps
module mbrf_formatter
   import mbrf_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] b_len_i,
   input wire logic [3:0] chan_state_i,
   input wire logic [13:0] channel_config_report_i,
   input wire logic [1:0] msg_valid_i,
   input wire mbrf_msg_t [1:0] msg_i,
   input wire logic cs_n_i,
   input wire logic [1:0] lost_clear_i,
   output logic [15:0] satellite_channel_one_o,
   output logic [15:0] satellite_channel_two_o,
   output logic [1:0] buffer_lost_flag_o,
   output logic [1:0] fifo_ready_o
);
   logic rst_meta;
   logic rst_n;
   logic cs_meta;
   logic cs_sync;
   mbrf_cs_state_t cs_state;
   logic pop;
   logic cfg_pending;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // chip select comes from the host pin, so synchronise first
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
      end else begin
         cs_meta <= cs_n_i;
         cs_sync <= cs_meta;
      end
   end

   // pop fires once per frame on the chip select rising edge
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cs_state <= MBRF_CS_IDLE;
      end else begin
         case (cs_state)
            MBRF_CS_IDLE: if (!cs_sync) cs_state <= MBRF_CS_LOW;
            MBRF_CS_LOW: if (cs_sync) cs_state <= MBRF_CS_POP;
            MBRF_CS_POP: cs_state <= cs_sync ? MBRF_CS_IDLE : MBRF_CS_LOW;
            default: cs_state <= MBRF_CS_IDLE;
         endcase
      end
   end
   assign pop = (cs_state == MBRF_CS_POP);

   // channel one shows its config report until the first frame ends
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cfg_pending <= 1'b1;
      end else if (pop) begin
         cfg_pending <= 1'b0;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         logic [3:0] len;
         logic [3:0] nb;
         logic [11:0] entry;
         logic push;
         logic in_ready;
         logic out_valid;
         logic [11:0] out_data;
         logic [11:0] head;
         logic lost;
         logic [1:0] st;
         logic [12:0] body;
         logic [15:0] word;

         // out-of-range settings clamp, keeping the fault logic defined
         always_comb begin
            len = b_len_i[ch*4 +: 4];
            if (len < MBRF_LEN_MIN) len = MBRF_LEN_MIN;
            if (len > MBRF_LEN_MAX) len = MBRF_LEN_MAX;
         end
         assign nb = msg_i[ch].nbits;

         // fault priority: timing or too few bits, then too many bits, then parity
         always_comb begin
            if (msg_i[ch].bit_time_err || nb < len) begin
               entry = MBRF_FC_BITTIME;
            end else if (nb > len) begin
               entry = MBRF_FC_TOO_MANY;
            end else if (msg_i[ch].parity_err) begin
               entry = MBRF_FC_PARITY;
            end else begin
               // right aligned, upper bits zero, marker set
               entry = {1'b1, msg_i[ch].data & ((11'h001 << len) - 11'h001)};
            end
         end

         assign push = msg_valid_i[ch] && st != MBRF_ST_OFF;

         mbrf_fifo #(
            .WIDTH(MBRF_ENTRY_W),
            .DEPTH(MBRF_FIFO_DEPTH)
         ) u_fifo (
            .clk_i(clk_i),
            .rst_n_i(rst_n),
            .in_valid_i(push),
            .in_ready_o(in_ready),
            .in_data_i(entry),
            .out_valid_o(out_valid),
            .out_ready_i(pop),
            .out_data_o(out_data)
         );
         assign fifo_ready_o[ch] = in_ready;

         // set wins over clear so a drop is never hidden
         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               lost <= 1'b0;
            end else if (push && !in_ready) begin
               lost <= 1'b1;
            end else if (lost_clear_i[ch]) begin
               lost <= 1'b0;
            end
         end
         assign buffer_lost_flag_o[ch] = lost;

         assign head = out_valid ? out_data : MBRF_FC_EMPTY;
         assign st = chan_state_i[ch*2 +: 2];
         assign body = {lost, head};

         // report words are registered; parity on bit 13 keeps 14 bits odd
         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               // empty config report still needs its parity bit set
               word <= (ch == 0) ? {MBRF_ST_CFG, 1'b1, 13'h0000} : MBRF_CH2_RESET;
            end else if (ch == 0 && cfg_pending) begin
               word <= {MBRF_ST_CFG, ~^channel_config_report_i[12:0],
                        channel_config_report_i[12:0]};
            end else begin
               word <= {st, ~^body, body};
            end
         end
      end
   endgenerate

   assign satellite_channel_one_o = g_ch[0].word;
   assign satellite_channel_two_o = g_ch[1].word;
endmodule

// *** mbrf_host.sv ***
// host model that frames one chip select read
`timescale 1ns/1ps
module mbrf_host (
   input wire logic clk_i,
   input wire logic rd_i,
   output logic cs_n_o
);
   // four cycles low, one spare above the minimum of three
   logic [2:0] cnt = 3'h0;
   always_ff @(posedge clk_i)
      if (rd_i) cnt <= 3'h4;
      else if (cnt != 3'h0) cnt <= cnt - 3'h1;
   assign cs_n_o = cnt == 3'h0;
endmodule

// *** mbrf_props.sv ***
// assertions on the report formatter ports
`timescale 1ns/1ps
module mbrf_props
   import mbrf_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [3:0] chan_state_i,
   input wire logic [13:0] channel_config_report_i,
   input wire logic [1:0] msg_valid_i,
   input wire logic cs_n_i,
   input wire logic [1:0] lost_clear_i,
   input wire logic [15:0] satellite_channel_one_o,
   input wire logic [15:0] satellite_channel_two_o,
   input wire logic [1:0] buffer_lost_flag_o,
   input wire logic [1:0] fifo_ready_o
);
   // outputs lag the reset release by the two sync flops and the report register
   logic [1:0] up;
   logic ok;
   always_ff @(posedge clk_i or negedge nrst_i)
      if (!nrst_i) up <= 2'h0;
      else if (up != 2'h3) up <= up + 2'h1;
   assign ok = up == 2'h3;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_cs_frame;
      !cs_n_i [*3] ##1 cs_n_i;
   endsequence
   sequence s_full_push;
      msg_valid_i[1] && !fifo_ready_o[1] && chan_state_i[3:2] != 2'h0;
   endsequence
   a_ch2_reset_val: assert property ($rose(nrst_i) |-> satellite_channel_two_o == MBRF_CH2_RESET)
      else $error("ch2 reset value");
   a_par_one: assert property (ok |-> ^satellite_channel_one_o[13:0])
      else $error("ch1 parity");
   a_cfg_copy: assert property (ok && satellite_channel_one_o[15:14] == 2'h3
      |-> satellite_channel_one_o[12:0] == channel_config_report_i[12:0])
      else $error("ch1 cfg content");
   a_cfg_leave: assert property (s_cs_frame |-> ##5 satellite_channel_one_o[15:14] == chan_state_i[1:0])
      else $error("ch1 state after pop");
   a_state_two: assert property (ok && $stable(chan_state_i) |-> satellite_channel_two_o[15:14] == chan_state_i[3:2])
      else $error("ch2 state");
   a_lost_bit: assert property (ok |-> ^satellite_channel_two_o[13:0]
      && satellite_channel_two_o[12] == $past(buffer_lost_flag_o[1]))
      else $error("ch2 lost bit");
   a_lost_set: assert property (s_full_push |=> buffer_lost_flag_o[1])
      else $error("lost flag not set");
   a_lost_hold: assert property (buffer_lost_flag_o[1] && !lost_clear_i[1] |=> buffer_lost_flag_o[1])
      else $error("lost flag dropped");
   a_full_head: assert property (ok && !fifo_ready_o[1] |-> satellite_channel_two_o[11:0] != 12'h0)
      else $error("full fifo head");
endmodule
bind mbrf_formatter mbrf_props u_props (.*);

// *** testbench.sv ***
// bench for the report formatter with a host model
`timescale 1ns/1ps
module testbench
   import mbrf_pkg::*;
;
   logic clk_i = 1'b0, nrst_i = 1'b0, cs_n_i, rd = 1'b0;
   logic [7:0] b_len_i = 8'h88;
   logic [3:0] chan_state_i = 4'ha;
   logic [13:0] cfg = 14'h3234;
   logic [1:0] msg_valid_i = 2'h0, lost_clear_i = 2'h0, fl, rdy;
   mbrf_msg_t [1:0] msg_i = '0;
   logic [15:0] w1, w2;
   logic [16:0] tc [5] = '{17'h2960, 17'h6964, 17'h095c, 17'h2961, 17'h2962};
   logic [11:0] th [5] = '{12'h8a5, MBRF_FC_TOO_MANY, MBRF_FC_BITTIME, MBRF_FC_PARITY, MBRF_FC_BITTIME};
   int errors = 0, cmp_count = 0;
   mbrf_formatter uut (.clk_i, .nrst_i, .b_len_i, .chan_state_i, .channel_config_report_i(cfg), .msg_valid_i,
      .msg_i, .cs_n_i, .lost_clear_i, .satellite_channel_one_o(w1), .satellite_channel_two_o(w2),
      .buffer_lost_flag_o(fl), .fifo_ready_o(rdy));
   mbrf_host host (.clk_i, .rd_i(rd), .cs_n_o(cs_n_i));
   initial forever #5 clk_i = ~clk_i;
   function automatic logic [15:0] wd(input logic [1:0] st, input logic l, input logic [11:0] h);
      return {st, ~^{l, h}, l, h};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic send(input logic [16:0] m);
      msg_i[1] = m;
      msg_valid_i = 2'h2;
      @(negedge clk_i);
      msg_valid_i = 2'h0;
      repeat (2) @(negedge clk_i);
   endtask
   // pop lands four edges after the chip select rises
   task automatic pop;
      rd = 1'b1;
      @(negedge clk_i);
      rd = 1'b0;
      repeat (12) @(negedge clk_i);
   endtask
   task automatic end_sim;
      if (errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #50us;
      errors++;
      end_sim;
   end
   initial begin
      repeat (2) @(negedge clk_i);
      chk("ch2 reset", MBRF_CH2_RESET, w2);
      nrst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      chk("ch1 cfg", {2'h3, ~^cfg[12:0], cfg[12:0]}, w1);
      for (int i = 0; i < 5; i++) begin
         send(tc[i]);
         chk("code", wd(2'h2, 1'b0, th[i]), w2);
         pop;
         chk("empty", wd(2'h2, 1'b0, MBRF_FC_EMPTY), w2);
      end
      chk("ch1 state", wd(2'h2, 1'b0, MBRF_FC_EMPTY), w1);
      msg_i[0] = tc[3];
      msg_valid_i = 2'h1;
      @(negedge clk_i);
      msg_valid_i = 2'h0;
      repeat (2) @(negedge clk_i);
      chk("ch1 code", wd(2'h2, 1'b0, MBRF_FC_PARITY), w1);
      chk("ch1 flags", 16'h2, {14'h0, rdy[0], fl[0]});
      pop;
      chk("ch1 empty", wd(2'h2, 1'b0, MBRF_FC_EMPTY), w1);
      for (int l = 8; l < 12; l++) begin
         b_len_i = {l[3:0], 4'h8};
         send({11'h7ff >> (11 - l), l[3:0], 2'h0});
         chk("len", wd(2'h2, 1'b0, 12'h800 | (12'hfff >> (12 - l))), w2);
         pop;
      end
      b_len_i = 8'h88;
      chan_state_i = 4'h2;
      send(tc[0]);
      chk("off", wd(2'h0, 1'b0, MBRF_FC_EMPTY), w2);
      chan_state_i = 4'h6;
      repeat (2) @(negedge clk_i);
      chk("disabled", wd(2'h1, 1'b0, MBRF_FC_EMPTY), w2);
      chan_state_i = 4'ha;
      msg_i[1] = tc[0];
      msg_valid_i = 2'h2;
      repeat (17) @(negedge clk_i);
      msg_valid_i = 2'h0;
      repeat (2) @(negedge clk_i);
      chk("full", 16'h1, {14'h0, rdy[1], fl[1]});
      chk("lost word", wd(2'h2, 1'b1, 12'h8a5), w2);
      lost_clear_i = 2'h2;
      @(negedge clk_i);
      lost_clear_i = 2'h0;
      @(negedge clk_i);
      chk("clear", 16'h0, {15'h0, fl[1]});
      repeat (16) pop;
      chk("drain", wd(2'h2, 1'b0, MBRF_FC_EMPTY), w2);
      end_sim;
   end
endmodule
